// file: rtl/ppc_pkg.sv
package ppc_pkg;

  // ----------------------------------------------------------------
  // privilege levels
  // ----------------------------------------------------------------
  localparam logic [1:0] RING_ZERO = 2'h0;
  localparam logic [1:0] RING_USER = 2'h3;

  // ----------------------------------------------------------------
  // instruction identities presented by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ins_other = 6'h00,
    ins_requestor_level_adjust = 6'h01,
    ins_global_intr_flag_clear = 6'h02,
    ins_intr_flag_clear = 6'h03,
    ins_intr_flag_set = 6'h04,
    ins_task_switched_clear = 6'h05,
    ins_halt_instr = 6'h06,
    ins_breakpoint_instr = 6'h07,
    ins_cache_invalidate_instr = 6'h08,
    ins_tlb_entry_invalidate = 6'h09,
    ins_tlb_entry_invalidate_by_asid = 6'h0A,
    ins_interrupt_return_instr = 6'h0B,
    ins_access_rights_load = 6'h0C,
    ins_global_table_base_load = 6'h0D,
    ins_interrupt_table_base_load = 6'h0E,
    ins_local_table_load = 6'h0F,
    ins_machine_status_load = 6'h10,
    ins_segment_limit_load = 6'h11,
    ins_task_reg_load = 6'h12,
    ins_monitor_setup = 6'h13,
    ins_control_reg_move = 6'h14,
    ins_debug_reg_move = 6'h15,
    ins_monitor_wait_instr = 6'h16,
    ins_model_reg_read = 6'h17,
    ins_perf_counter_read = 6'h18,
    ins_timestamp_read = 6'h19,
    ins_timestamp_and_cpu_id_read = 6'h1A,
    ins_sysmgmt_mode_return = 6'h1B,
    ins_global_table_base_store = 6'h1C,
    ins_interrupt_table_base_store = 6'h1D,
    ins_secure_init_jump = 6'h1E,
    ins_local_table_store = 6'h1F,
    ins_machine_status_store = 6'h20,
    ins_task_reg_store = 6'h21
  } ppc_instr_t;

  // ----------------------------------------------------------------
  // privilege classes and the software control that steers os class
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    cls_any = 2'h0,
    cls_ring0 = 2'h1,
    cls_os = 2'h2
  } ppc_class_t;

  typedef enum logic [2:0] {
    os_none = 3'h0,
    os_intr_flag = 3'h1,
    os_monitor = 3'h2,
    os_perf = 3'h3,
    os_timestamp = 3'h4
  } ppc_os_sel_t;

  // ----------------------------------------------------------------
  // fault codes reported with a suppressed access or instruction
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    flt_none = 2'h0,
    flt_general_protection = 2'h1,
    flt_stack = 2'h2,
    flt_page_access = 2'h3
  } ppc_fault_t;

endpackage : ppc_pkg

// file: rtl/ppc_class_table.sv
// registered lookup of the privilege class of one decoded instruction
module ppc_class_table
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [5:0] instr_code,
  output ppc_pkg::ppc_class_t cls_q,
  output ppc_pkg::ppc_os_sel_t os_sel_q
);

  // ----------------------------------------------------------------
  // class decode
  // ----------------------------------------------------------------
  function automatic logic [4:0] classify(input logic [5:0] code);
    ppc_pkg::ppc_instr_t ins;
    logic [4:0] res;
    ins = ppc_pkg::ppc_instr_t'(code);
    res = {ppc_pkg::cls_any, ppc_pkg::os_none};
    case (ins)
      ppc_pkg::ins_global_intr_flag_clear,
      ppc_pkg::ins_task_switched_clear,
      ppc_pkg::ins_halt_instr,
      ppc_pkg::ins_cache_invalidate_instr,
      ppc_pkg::ins_tlb_entry_invalidate,
      ppc_pkg::ins_tlb_entry_invalidate_by_asid,
      ppc_pkg::ins_global_table_base_load,
      ppc_pkg::ins_interrupt_table_base_load,
      ppc_pkg::ins_local_table_load,
      ppc_pkg::ins_machine_status_load,
      ppc_pkg::ins_task_reg_load,
      ppc_pkg::ins_control_reg_move,
      ppc_pkg::ins_debug_reg_move,
      ppc_pkg::ins_model_reg_read,
      ppc_pkg::ins_secure_init_jump:
        res = {ppc_pkg::cls_ring0, ppc_pkg::os_none};
      ppc_pkg::ins_intr_flag_clear,
      ppc_pkg::ins_intr_flag_set:
        res = {ppc_pkg::cls_os, ppc_pkg::os_intr_flag};
      ppc_pkg::ins_monitor_setup,
      ppc_pkg::ins_monitor_wait_instr:
        res = {ppc_pkg::cls_os, ppc_pkg::os_monitor};
      ppc_pkg::ins_perf_counter_read:
        res = {ppc_pkg::cls_os, ppc_pkg::os_perf};
      ppc_pkg::ins_timestamp_read,
      ppc_pkg::ins_timestamp_and_cpu_id_read:
        res = {ppc_pkg::cls_os, ppc_pkg::os_timestamp};
      // unlisted codes are not system instructions: any level
      default:
        res = {ppc_pkg::cls_any, ppc_pkg::os_none};
    endcase
    return res;
  endfunction : classify

  wire logic [4:0] cls_d = classify(instr_code);

  // table output is registered so the gate stage sees a clean value
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cls_q <= ppc_pkg::cls_any;
      os_sel_q <= ppc_pkg::os_none;
    end
    else
    begin
      cls_q <= ppc_pkg::ppc_class_t'(cls_d[4:3]);
      os_sel_q <= ppc_pkg::ppc_os_sel_t'(cls_d[2:0]);
    end
  end

  chk_halt_class : assert property (
    @(posedge clk) disable iff (!rstn)
    instr_code == ppc_pkg::ins_halt_instr |=> cls_q == ppc_pkg::cls_ring0)
    else $error("halt not classed ring zero");

endmodule : ppc_class_table

// file: rtl/ppc_checker.sv
module ppc_checker
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] current_ring_level,
  input wire logic write_protect_enable,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic seg_violation,
  input wire logic seg_stack_fault,
  input wire logic page_present,
  input wire logic page_user,
  input wire logic page_writable,
  input wire logic instr_valid,
  input wire logic [5:0] instr_code,
  input wire logic [1:0] intr_level_limit,
  input wire logic monitor_user_allow,
  input wire logic perf_user_allow,
  input wire logic timestamp_restrict,
  output logic mem_issue,
  output logic mem_suppress,
  output ppc_pkg::ppc_fault_t mem_fault,
  output logic instr_execute,
  output logic instr_suppress,
  output ppc_pkg::ppc_fault_t instr_fault
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // access path, stage one: segment result
  // ----------------------------------------------------------------
  logic s1_valid_q;
  logic s1_write_q;
  logic s1_super_q;
  logic s1_wp_q;
  logic s1_seg_bad_q;
  logic s1_seg_stack_q;
  logic s1_present_q;
  logic s1_user_q;
  logic s1_rw_q;

  // any ring below user counts as supervisor
  wire logic is_super = current_ring_level != ppc_pkg::RING_USER;

  // the segment verdict and the page bits are captured together; both are judged a stage later
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s1_valid_q <= 1'b0;
      s1_write_q <= 1'b0;
      s1_super_q <= 1'b0;
      s1_wp_q <= 1'b0;
      s1_seg_bad_q <= 1'b0;
      s1_seg_stack_q <= 1'b0;
      s1_present_q <= 1'b0;
      s1_user_q <= 1'b0;
      s1_rw_q <= 1'b0;
    end
    else
    begin
      s1_valid_q <= acc_valid;
      s1_write_q <= acc_write;
      s1_super_q <= is_super;
      s1_wp_q <= write_protect_enable;
      s1_seg_bad_q <= seg_violation;
      s1_seg_stack_q <= seg_stack_fault;
      s1_present_q <= page_present;
      s1_user_q <= page_user;
      s1_rw_q <= page_writable;
    end
  end

  // ----------------------------------------------------------------
  // access path, stage two: page protection
  // ----------------------------------------------------------------
  // user code may touch only user pages and writes need all entries
  // writable; supervisor writes to read-only pages pass unless wp is
  // set, which is the only place the wp bit matters for user pages
  wire logic user_denied = !s1_user_q || (s1_write_q && !s1_rw_q);
  wire logic super_denied = s1_write_q && !s1_rw_q && s1_wp_q;
  wire logic page_denied = !s1_present_q ||
    (s1_super_q ? super_denied : user_denied);
  // the page stage is only consulted when the segment passed
  wire logic page_bad = s1_valid_q && !s1_seg_bad_q && page_denied;
  wire logic seg_bad = s1_valid_q && s1_seg_bad_q;
  wire logic acc_ok = s1_valid_q && !s1_seg_bad_q && !page_denied;

  // segment faults never map to the page fault code
  wire ppc_pkg::ppc_fault_t seg_code = s1_seg_stack_q ?
    ppc_pkg::flt_stack : ppc_pkg::flt_general_protection;
  wire ppc_pkg::ppc_fault_t mem_fault_d = seg_bad ? seg_code :
    page_bad ? ppc_pkg::flt_page_access : ppc_pkg::flt_none;

  logic mem_issue_q;
  logic mem_suppress_q;
  ppc_pkg::ppc_fault_t mem_fault_q;

  // a faulting access never reaches memory
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      mem_issue_q <= 1'b0;
      mem_suppress_q <= 1'b0;
      mem_fault_q <= ppc_pkg::flt_none;
    end
    else
    begin
      mem_issue_q <= acc_ok;
      mem_suppress_q <= seg_bad || page_bad;
      mem_fault_q <= mem_fault_d;
    end
  end

  assign mem_issue = mem_issue_q;
  assign mem_suppress = mem_suppress_q;
  assign mem_fault = mem_fault_q;

  // ----------------------------------------------------------------
  // instruction path: class lookup plus captured context
  // ----------------------------------------------------------------
  ppc_pkg::ppc_class_t cls_q;
  ppc_pkg::ppc_os_sel_t os_sel_q;

  ppc_class_table u_class_table
  (
    .clk(clk),
    .rstn(rstn),
    .instr_code(instr_code),
    .cls_q(cls_q),
    .os_sel_q(os_sel_q)
  );

  logic i1_valid_q;
  logic [1:0] i1_ring_q;
  logic [1:0] i1_limit_q;
  logic i1_mon_q;
  logic i1_perf_q;
  logic i1_tsr_q;

  // context is sampled with the code so a later change of the
  // software controls cannot leak into an instruction in flight
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      i1_valid_q <= 1'b0;
      i1_ring_q <= ppc_pkg::RING_ZERO;
      i1_limit_q <= ppc_pkg::RING_ZERO;
      i1_mon_q <= 1'b0;
      i1_perf_q <= 1'b0;
      i1_tsr_q <= 1'b0;
    end
    else
    begin
      i1_valid_q <= instr_valid;
      i1_ring_q <= current_ring_level;
      i1_limit_q <= intr_level_limit;
      i1_mon_q <= monitor_user_allow;
      i1_perf_q <= perf_user_allow;
      i1_tsr_q <= timestamp_restrict;
    end
  end

  // ----------------------------------------------------------------
  // privilege gate
  // ----------------------------------------------------------------
  wire logic at_ring0 = i1_ring_q == ppc_pkg::RING_ZERO;

  // software-chosen level for each os-controlled group
  function automatic logic os_grant(
    input ppc_pkg::ppc_os_sel_t sel,
    input logic ring0,
    input logic [1:0] ring,
    input logic [1:0] limit,
    input logic mon,
    input logic perf,
    input logic tsr
  );
    logic g;
    g = ring0;
    case (sel)
      ppc_pkg::os_intr_flag: g = ring <= limit;
      ppc_pkg::os_monitor: g = ring0 || mon;
      ppc_pkg::os_perf: g = ring0 || perf;
      ppc_pkg::os_timestamp: g = ring0 || !tsr;
      default: g = ring0;
    endcase
    return g;
  endfunction : os_grant

  wire logic os_ok = os_grant(os_sel_q, at_ring0, i1_ring_q, i1_limit_q,
    i1_mon_q, i1_perf_q, i1_tsr_q);
  // ring-zero class, os class, or any level
  wire logic instr_ok = (cls_q == ppc_pkg::cls_any) ||
    ((cls_q == ppc_pkg::cls_ring0) && at_ring0) ||
    ((cls_q == ppc_pkg::cls_os) && os_ok);
  wire logic instr_denied = i1_valid_q && !instr_ok;

  logic instr_execute_q;
  logic instr_suppress_q;
  ppc_pkg::ppc_fault_t instr_fault_q;

  // a denied instruction only faults; execute stays low so the
  // core commits none of its side effects
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      instr_execute_q <= 1'b0;
      instr_suppress_q <= 1'b0;
      instr_fault_q <= ppc_pkg::flt_none;
    end
    else
    begin
      instr_execute_q <= i1_valid_q && instr_ok;
      instr_suppress_q <= instr_denied;
      instr_fault_q <= instr_denied ? ppc_pkg::flt_general_protection :
        ppc_pkg::flt_none;
    end
  end

  assign instr_execute = instr_execute_q;
  assign instr_suppress = instr_suppress_q;
  assign instr_fault = instr_fault_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_wp_super_write : assert property (
    acc_valid && acc_write && is_super && write_protect_enable &&
    !seg_violation && page_present && page_user && !page_writable
    |-> ##2 mem_fault == ppc_pkg::flt_page_access && !mem_issue)
    else $error("wp supervisor write to read-only user page passed");

  chk_wp_clear_write : assert property (
    acc_valid && acc_write && is_super && !write_protect_enable &&
    !seg_violation && page_present && page_user
    |-> ##2 mem_issue && mem_fault == ppc_pkg::flt_none)
    else $error("supervisor write blocked with wp clear");

  chk_user_ro_write : assert property (
    acc_valid && acc_write && !is_super && !seg_violation &&
    page_present && !page_writable
    |-> ##2 mem_fault == ppc_pkg::flt_page_access)
    else $error("user write to read-only page passed");

  chk_seg_first : assert property (
    acc_valid && seg_violation
    |-> ##2 mem_fault != ppc_pkg::flt_page_access && mem_suppress)
    else $error("segment violation reported as page fault");

  chk_seg_kind : assert property (
    acc_valid && seg_violation && seg_stack_fault
    |-> ##2 mem_fault == ppc_pkg::flt_stack)
    else $error("stack segment fault code wrong");

  chk_fault_blocks : assert property (
    mem_fault != ppc_pkg::flt_none |-> !mem_issue && mem_suppress)
    else $error("memory issued alongside a fault");

  chk_page_missing : assert property (
    acc_valid && !seg_violation && !page_present
    |-> ##2 mem_fault == ppc_pkg::flt_page_access)
    else $error("missing page did not raise page fault");

  chk_ring0_gate : assert property (
    instr_valid && current_ring_level != ppc_pkg::RING_ZERO &&
    (instr_code == ppc_pkg::ins_global_intr_flag_clear ||
     instr_code == ppc_pkg::ins_task_switched_clear ||
     instr_code == ppc_pkg::ins_cache_invalidate_instr ||
     instr_code == ppc_pkg::ins_control_reg_move ||
     instr_code == ppc_pkg::ins_secure_init_jump)
    |-> ##2 instr_fault == ppc_pkg::flt_general_protection &&
    !instr_execute)
    else $error("ring zero instruction ran outside ring zero");

  chk_intr_os : assert property (
    instr_valid && instr_code == ppc_pkg::ins_intr_flag_clear &&
    current_ring_level <= intr_level_limit |-> ##2 instr_execute)
    else $error("interrupt flag clear refused within limit");

  chk_tsc_os : assert property (
    instr_valid && instr_code == ppc_pkg::ins_timestamp_read &&
    current_ring_level != ppc_pkg::RING_ZERO && timestamp_restrict
    |-> ##2 instr_suppress)
    else $error("restricted timestamp read allowed");

  chk_any_level : assert property (
    instr_valid && (instr_code == ppc_pkg::ins_breakpoint_instr ||
    instr_code == ppc_pkg::ins_task_reg_store ||
    instr_code == ppc_pkg::ins_interrupt_return_instr)
    |-> ##2 instr_execute && !instr_suppress)
    else $error("any-level instruction refused");

  chk_deny_quiet : assert property (
    instr_suppress |-> !instr_execute &&
    instr_fault == ppc_pkg::flt_general_protection)
    else $error("denied instruction executed");

endmodule : ppc_checker

// file: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // design hookup
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] ring = 2'h0;
  logic wp_en = 1'b0;
  logic acc_valid = 1'b0;
  logic acc_write = 1'b0;
  logic seg_violation = 1'b0;
  logic seg_stack_fault = 1'b0;
  logic page_present = 1'b0;
  logic page_user = 1'b0;
  logic page_writable = 1'b0;
  logic instr_valid = 1'b0;
  logic [5:0] instr_code = 6'h00;
  logic [1:0] intr_level_limit = 2'h0;
  logic monitor_user_allow = 1'b0;
  logic perf_user_allow = 1'b0;
  logic timestamp_restrict = 1'b0;
  logic mem_issue;
  logic mem_suppress;
  ppc_pkg::ppc_fault_t mem_fault;
  logic instr_execute;
  logic instr_suppress;
  ppc_pkg::ppc_fault_t instr_fault;
  int n_errors = 0;
  int n_compared = 0;

  ppc_checker dut_u
  (
    .clk(clk),
    .rstn(rstn),
    .current_ring_level(ring),
    .write_protect_enable(wp_en),
    .acc_valid(acc_valid),
    .acc_write(acc_write),
    .seg_violation(seg_violation),
    .seg_stack_fault(seg_stack_fault),
    .page_present(page_present),
    .page_user(page_user),
    .page_writable(page_writable),
    .instr_valid(instr_valid),
    .instr_code(instr_code),
    .intr_level_limit(intr_level_limit),
    .monitor_user_allow(monitor_user_allow),
    .perf_user_allow(perf_user_allow),
    .timestamp_restrict(timestamp_restrict),
    .mem_issue(mem_issue),
    .mem_suppress(mem_suppress),
    .mem_fault(mem_fault),
    .instr_execute(instr_execute),
    .instr_suppress(instr_suppress),
    .instr_fault(instr_fault)
  );

  // 10 MHz core clock
  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_flt(input string what, input ppc_pkg::ppc_fault_t exp,
                         input ppc_pkg::ppc_fault_t got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_flt

  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // request tasks: drive after an edge, answer lands two edges later
  // ----------------------------------------------------------------
  task automatic acc_check(input ppc_pkg::ppc_fault_t ef);
    chk_bit("mem_issue", ef == ppc_pkg::flt_none, mem_issue);
    chk_bit("mem_suppress", ef != ppc_pkg::flt_none, mem_suppress);
    chk_flt("mem_fault", ef, mem_fault);
  endtask : acc_check

  task automatic acc_drive(input logic [1:0] r, input logic wp, wr, sv, ss,
                           pp, pu, pw);
    ring <= r;
    wp_en <= wp;
    acc_write <= wr;
    seg_violation <= sv;
    seg_stack_fault <= ss;
    page_present <= pp;
    page_user <= pu;
    page_writable <= pw;
    acc_valid <= 1'b1;
  endtask : acc_drive

  task automatic do_acc(input logic [1:0] r, input logic wp, wr, sv, ss,
                        pp, pu, pw, input ppc_pkg::ppc_fault_t ef);
    @(posedge clk);
    acc_drive(r, wp, wr, sv, ss, pp, pu, pw);
    @(posedge clk);
    acc_valid <= 1'b0;
    // answer was registered at this edge, one after the taking edge
    @(posedge clk);
    #1;
    acc_check(ef);
  endtask : do_acc

  task automatic do_ins(input ppc_pkg::ppc_instr_t code, input logic [1:0] r,
                        input logic ok);
    @(posedge clk);
    ring <= r;
    instr_code <= code;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    // look while the one-cycle answer still stands
    @(posedge clk);
    #1;
    chk_bit("instr_execute", ok, instr_execute);
    chk_bit("instr_suppress", !ok, instr_suppress);
    chk_flt("instr_fault", ok ? ppc_pkg::flt_none
            : ppc_pkg::flt_general_protection, instr_fault);
  endtask : do_ins

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // supervisor writes to read-only user pages hinge on the wp bit only
  task automatic sc_write_protect;
    for (int r = 0; r < 3; r++)
    begin
      do_acc(r[1:0], 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
             ppc_pkg::flt_page_access);
      do_acc(r[1:0], 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
             ppc_pkg::flt_none);
    end
  endtask : sc_write_protect

  // user level sees the same grants whichever way wp is set
  task automatic sc_user_pages;
    for (int w = 0; w < 2; w++)
    begin
      do_acc(2'h3, w[0], 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
             ppc_pkg::flt_page_access);
      do_acc(2'h3, w[0], 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
             ppc_pkg::flt_none);
      do_acc(2'h3, w[0], 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
             ppc_pkg::flt_page_access);
    end
  endtask : sc_user_pages

  // a segment fault hides a page fault that would otherwise fire
  task automatic sc_segment_first;
    do_acc(2'h3, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
           ppc_pkg::flt_general_protection);
    do_acc(2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
           ppc_pkg::flt_stack);
    do_acc(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1,
           ppc_pkg::flt_page_access);
  endtask : sc_segment_first

  // back to back: a fault must not leak an issue into its neighbour
  task automatic sc_back_to_back;
    @(posedge clk);
    acc_drive(2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    acc_drive(2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    acc_check(ppc_pkg::flt_page_access);
    @(posedge clk);
    #1;
    acc_check(ppc_pkg::flt_none);
  endtask : sc_back_to_back

  // ring-zero class at every level, and the any-level class at user level
  task automatic sc_fixed_classes;
    ppc_pkg::ppc_instr_t r0[15];
    ppc_pkg::ppc_instr_t anyl[11];
    r0 = '{ppc_pkg::ins_global_intr_flag_clear,
           ppc_pkg::ins_task_switched_clear, ppc_pkg::ins_halt_instr,
           ppc_pkg::ins_cache_invalidate_instr,
           ppc_pkg::ins_tlb_entry_invalidate,
           ppc_pkg::ins_tlb_entry_invalidate_by_asid,
           ppc_pkg::ins_global_table_base_load,
           ppc_pkg::ins_interrupt_table_base_load,
           ppc_pkg::ins_local_table_load, ppc_pkg::ins_machine_status_load,
           ppc_pkg::ins_task_reg_load, ppc_pkg::ins_control_reg_move,
           ppc_pkg::ins_debug_reg_move, ppc_pkg::ins_model_reg_read,
           ppc_pkg::ins_secure_init_jump};
    anyl = '{ppc_pkg::ins_requestor_level_adjust,
             ppc_pkg::ins_access_rights_load,
             ppc_pkg::ins_segment_limit_load,
             ppc_pkg::ins_interrupt_return_instr,
             ppc_pkg::ins_sysmgmt_mode_return,
             ppc_pkg::ins_breakpoint_instr,
             ppc_pkg::ins_global_table_base_store,
             ppc_pkg::ins_interrupt_table_base_store,
             ppc_pkg::ins_local_table_store,
             ppc_pkg::ins_machine_status_store,
             ppc_pkg::ins_task_reg_store};
    foreach (r0[i])
      for (int r = 0; r < 4; r++)
        do_ins(r0[i], r[1:0], r == 0);
    foreach (anyl[i])
      do_ins(anyl[i], 2'h3, 1'b1);
  endtask : sc_fixed_classes

  // software-steered class follows its control inputs
  task automatic sc_os_classes;
    for (int a = 0; a < 2; a++)
    begin
      @(posedge clk);
      monitor_user_allow <= a[0];
      perf_user_allow <= a[0];
      timestamp_restrict <= !a[0];
      intr_level_limit <= a[0] ? 2'h3 : 2'h1;
      do_ins(ppc_pkg::ins_monitor_setup, 2'h2, a[0]);
      do_ins(ppc_pkg::ins_monitor_wait_instr, 2'h2, a[0]);
      do_ins(ppc_pkg::ins_perf_counter_read, 2'h1, a[0]);
      do_ins(ppc_pkg::ins_timestamp_read, 2'h3, a[0]);
      do_ins(ppc_pkg::ins_timestamp_and_cpu_id_read, 2'h3, a[0]);
      do_ins(ppc_pkg::ins_timestamp_read, 2'h0, 1'b1);
      do_ins(ppc_pkg::ins_intr_flag_clear, 2'h1, 1'b1);
      do_ins(ppc_pkg::ins_intr_flag_clear, 2'h2, a[0]);
      do_ins(ppc_pkg::ins_intr_flag_set, 2'h3, a[0]);
    end
  endtask : sc_os_classes

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    sc_write_protect();
    sc_user_pages();
    sc_segment_first();
    sc_back_to_back();
    sc_fixed_classes();
    sc_os_classes();
    wrap_up();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #(3000 * 100);
    n_errors++;
    wrap_up();
  end

endmodule : testbench
